// ===== inc/addr_gen_pkg.sv
package addr_gen_pkg;

    // ****************************************************************
    // Branch modes for the next instruction pointer.
    // ****************************************************************
    typedef enum logic [2:0] {
        BR_NONE,
        BR_RELATIVE,
        BR_ABSOLUTE,
        BR_SHORT_CALL,
        BR_TABLE_CALL,
        BR_REGISTER
    } branch_mode_e;

    // ****************************************************************
    // Operand addressing modes.
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_IMPLIED,
        OP_REGISTER,
        OP_DIRECT,
        OP_SHORT_DIRECT,
        OP_SPECIAL,
        OP_INDIRECT_POINTER,
        OP_INDIRECT_BASE,
        OP_BASED,
        OP_BASED_INDEX_HIGH,
        OP_BASED_INDEX_LOW
    } operand_mode_e;

    localparam logic [15:0] SHORT_CALL_BASE = 16'h0800;
    localparam logic [15:0] TABLE_BASE = 16'h0040;
    localparam logic [7:0] SHORT_DIRECT_SPLIT = 8'h20;
    localparam logic [6:0] SHORT_DIRECT_HIGH = 7'h7f;
    localparam logic [7:0] SPECIAL_HIGH = 8'hff;
    localparam logic [15:0] RESET_POINTER = 16'h0000;

    // Byte register codes, in order.
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;

    // Pair register codes, in order.
    localparam logic [1:0] PAIR_ACC = 2'h0;
    localparam logic [1:0] PAIR_BC = 2'h1;
    localparam logic [1:0] PAIR_POINTER = 2'h2;
    localparam logic [1:0] PAIR_BASE = 2'h3;

endpackage

// ===== logic/addr_gen.sv
`timescale 1ns/1ns
module addr_gen
    import addr_gen_pkg::*;
(
    input wire logic REF_CLK, // core clock
    input wire logic RST_B, // asynchronous reset, active low
    input wire logic FETCH_DONE, // instruction fetched, pointer updates
    input wire logic [2:0] INSTR_LENGTH, // bytes in fetched instruction
    input wire branch_mode_e BRANCH_MODE, // branch taken and its kind
    input wire logic [7:0] SIGNED_BRANCH_DISPLACEMENT, // relative offset
    input wire logic [15:0] IMMEDIATE_WORD, // 16-bit immediate field
    input wire logic [10:0] SHORT_CALL_ADDR, // 11-bit call immediate
    input wire logic [7:0] OPCODE_BYTE, // opcode, bits 1-5 pick table
    input wire logic [15:0] TABLE_ENTRY, // word read from the table
    input wire operand_mode_e OPERAND_MODE, // operand addressing mode
    input wire logic [7:0] IMMEDIATE_BYTE, // 8-bit immediate field
    input wire logic [2:0] BYTE_REG_CODE, // byte register code
    input wire logic [1:0] PAIR_REG_CODE, // pair register code
    input wire logic PAIR_SELECT, // 1 selects pair code, 0 byte code
    input wire logic BANK_SELECT_LOW, // bank select flag 0
    input wire logic BANK_SELECT_HIGH, // bank select flag 1
    input wire logic [63:0] BANK_REGS, // selected bank, X in low byte
    input wire logic OPERAND_REQ, // operand address request
    output logic [15:0] INSTRUCTION_POINTER, // program counter
    output logic [15:0] TABLE_ADDR, // address of table entry to read
    output logic [15:0] OPERAND_ADDR, // memory effective address
    output logic OPERAND_IS_REG, // operand is a general register
    output logic [4:0] REG_INDEX, // register file byte index
    output logic REG_IS_PAIR, // register operand is a pair
    output logic OPERAND_VALID // address outputs updated this cycle
);

    // ****************************************************************
    // Helper functions.
    // ****************************************************************
    // Widens an unsigned byte for the based forms; the carry of the
    // sum that follows is dropped on purpose, so addresses wrap.
    function automatic logic [15:0] zext(input logic [7:0] value);
        zext = {8'h00, value};
    endfunction

    // Copies the sign bit of a branch offset into the upper byte.
    function automatic logic [15:0] sext(input logic [7:0] value);
        sext = {{8{value[7]}}, value};
    endfunction

    // Register file index of a byte or a pair in the chosen bank. The
    // implied and the named register forms both go through here.
    function automatic logic [4:0] reg_index(input logic [1:0] bank_sel,
                                             input logic is_pair,
                                             input logic [2:0] byte_code,
                                             input logic [1:0] pair_code);
        if (is_pair) begin
            reg_index = {bank_sel, pair_code, 1'b0};
        end else begin
            reg_index = {bank_sel, byte_code};
        end
    endfunction

    // ****************************************************************
    // Selected bank, unpacked into bytes and pairs.
    // ****************************************************************
    logic [1:0] bank;
    logic [7:0] bank_byte [8];
    logic [15:0] bank_pair [4];
    logic [15:0] accumulator_pair;
    logic [15:0] pointer_pair;
    logic [15:0] base_pair;
    logic [7:0] index_high;
    logic [7:0] index_low;

    assign bank = {BANK_SELECT_HIGH, BANK_SELECT_LOW};

    // Codes count up through the bank in order, so a byte code and the
    // pair code that covers it land on the same storage.
    genvar n;
    generate
        for (n = 0; n < 8; n = n + 1) begin : g_byte
            assign bank_byte[n] = BANK_REGS[n * 8 +: 8];
        end
        for (n = 0; n < 4; n = n + 1) begin : g_pair
            assign bank_pair[n] = BANK_REGS[n * 16 +: 16];
        end
    endgenerate

    assign accumulator_pair = bank_pair[PAIR_ACC];
    assign pointer_pair = bank_pair[PAIR_POINTER];
    assign base_pair = bank_pair[PAIR_BASE];
    assign index_high = bank_byte[REG_B];
    assign index_low = bank_byte[REG_C];

    // ****************************************************************
    // Branch targets.
    // ****************************************************************
    logic [15:0] sequential;
    logic [15:0] relative_target;
    logic [15:0] short_call_target;
    logic [15:0] next_pointer;

    // The next instruction starts right after the bytes just fetched.
    assign sequential = INSTRUCTION_POINTER + {13'h0000, INSTR_LENGTH};
    // The offset counts from the next instruction, not from this one.
    assign relative_target = sequential + sext(SIGNED_BRANCH_DISPLACEMENT);
    // Bit 11 is always set, which keeps the target between 0800h and
    // 0fffh whatever the 11-bit field holds.
    assign short_call_target = SHORT_CALL_BASE | {5'h00, SHORT_CALL_ADDR};
    // Table entries are words, so bits 1-5 address them directly.
    assign TABLE_ADDR = TABLE_BASE | {10'h000, OPCODE_BYTE[5:1], 1'b0};

    // ****************************************************************
    // Next instruction pointer.
    // ****************************************************************
    always_comb begin
        case (BRANCH_MODE)
            BR_NONE: begin
                next_pointer = sequential;
            end
            BR_RELATIVE: begin
                next_pointer = relative_target;
            end
            BR_ABSOLUTE: begin
                next_pointer = IMMEDIATE_WORD;
            end
            BR_SHORT_CALL: begin
                next_pointer = short_call_target;
            end
            BR_TABLE_CALL: begin
                next_pointer = TABLE_ENTRY;
            end
            BR_REGISTER: begin
                next_pointer = accumulator_pair;
            end
            default: begin
                // Unused codes fall back to a plain step.
                next_pointer = sequential;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            INSTRUCTION_POINTER <= RESET_POINTER;
        end else if (FETCH_DONE) begin
            INSTRUCTION_POINTER <= next_pointer;
        end
    end

    // ****************************************************************
    // Operand effective address.
    // ****************************************************************
    logic short_direct_upper;
    logic [15:0] short_direct_addr;
    logic [15:0] special_addr;
    logic [15:0] based_addr;
    logic [15:0] index_high_addr;
    logic [15:0] index_low_addr;
    logic [15:0] next_operand;

    // Immediates below 20h reach the register area from ff00h and the
    // rest reach RAM from fe20h, so the window is one 256-byte span.
    assign short_direct_upper = IMMEDIATE_BYTE < SHORT_DIRECT_SPLIT;
    assign short_direct_addr = {SHORT_DIRECT_HIGH, short_direct_upper,
                                IMMEDIATE_BYTE};
    assign special_addr = {SPECIAL_HIGH, IMMEDIATE_BYTE};
    assign based_addr = base_pair + zext(IMMEDIATE_BYTE);
    assign index_high_addr = base_pair + zext(index_high);
    assign index_low_addr = base_pair + zext(index_low);

    always_comb begin
        next_operand = 16'h0000;
        case (OPERAND_MODE)
            OP_DIRECT: begin
                next_operand = IMMEDIATE_WORD;
            end
            OP_SHORT_DIRECT: begin
                next_operand = short_direct_addr;
            end
            OP_SPECIAL: begin
                next_operand = special_addr;
            end
            OP_INDIRECT_POINTER: begin
                next_operand = pointer_pair;
            end
            OP_INDIRECT_BASE: begin
                next_operand = base_pair;
            end
            OP_BASED: begin
                next_operand = based_addr;
            end
            OP_BASED_INDEX_HIGH: begin
                next_operand = index_high_addr;
            end
            OP_BASED_INDEX_LOW: begin
                next_operand = index_low_addr;
            end
            default: begin
                // Register and implied forms name no memory address.
                next_operand = 16'h0000;
            end
        endcase
    end

    // ****************************************************************
    // Register operand select.
    // ****************************************************************
    logic next_is_reg;
    logic next_is_pair;
    logic [4:0] next_index;

    always_comb begin
        next_is_reg = 1'b0;
        next_is_pair = 1'b0;
        next_index = 5'h00;
        case (OPERAND_MODE)
            OP_IMPLIED: begin
                // Multiply, divide, adjust and rotate name no operand;
                // the accumulator is implied.
                next_is_reg = 1'b1;
                next_is_pair = PAIR_SELECT;
                next_index = reg_index(bank, PAIR_SELECT, REG_A, PAIR_ACC);
            end
            OP_REGISTER: begin
                next_is_reg = 1'b1;
                next_is_pair = PAIR_SELECT;
                next_index = reg_index(bank, PAIR_SELECT, BYTE_REG_CODE,
                                       PAIR_REG_CODE);
            end
            default: begin
                next_is_reg = 1'b0;
                next_is_pair = 1'b0;
                next_index = 5'h00;
            end
        endcase
    end

    // ****************************************************************
    // Operand outputs.
    // ****************************************************************
    // Each output but OPERAND_VALID holds until the next request, so the memory path may
    // use it for as long as the instruction needs.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            OPERAND_ADDR <= 16'h0000;
        end else if (OPERAND_REQ) begin
            OPERAND_ADDR <= next_operand;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            OPERAND_IS_REG <= 1'b0;
        end else if (OPERAND_REQ) begin
            OPERAND_IS_REG <= next_is_reg;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_INDEX <= 5'h00;
        end else if (OPERAND_REQ) begin
            REG_INDEX <= next_index;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_IS_PAIR <= 1'b0;
        end else if (OPERAND_REQ) begin
            REG_IS_PAIR <= next_is_pair;
        end
    end

    // Follows OPERAND_REQ one cycle later; back-to-back requests hold it high as a level.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            OPERAND_VALID <= 1'b0;
        end else begin
            OPERAND_VALID <= OPERAND_REQ;
        end
    end

endmodule

// ===== verification/addr_gen_properties.sv
`timescale 1ns/1ns
module addr_gen_properties
    import addr_gen_pkg::*;
(
    input wire logic REF_CLK, // clock
    input wire logic RST_B, // reset
    input wire logic FETCH_DONE, // fetch
    input wire logic [2:0] INSTR_LENGTH, // length
    input wire branch_mode_e BRANCH_MODE, // branch kind
    input wire logic [7:0] SIGNED_BRANCH_DISPLACEMENT, // offset
    input wire logic [15:0] IMMEDIATE_WORD, // word
    input wire logic [10:0] SHORT_CALL_ADDR, // call
    input wire logic [15:0] TABLE_ENTRY, // entry
    input wire operand_mode_e OPERAND_MODE, // mode
    input wire logic [7:0] IMMEDIATE_BYTE, // byte
    input wire logic [63:0] BANK_REGS, // bank
    input wire logic OPERAND_REQ, // request
    input wire logic [15:0] INSTRUCTION_POINTER, // pointer
    input wire logic [15:0] OPERAND_ADDR, // address
    input wire logic OPERAND_VALID // valid
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_br(branch_mode_e m);
        FETCH_DONE && BRANCH_MODE == m;
    endsequence
    sequence s_op(operand_mode_e m);
        OPERAND_REQ && OPERAND_MODE == m;
    endsequence
    property p_seq;
        s_br(BR_NONE) |=> INSTRUCTION_POINTER ==
            $past(INSTRUCTION_POINTER) + $past(INSTR_LENGTH);
    endproperty
    property p_rel;
        s_br(BR_RELATIVE) |=> INSTRUCTION_POINTER ==
            $past(INSTRUCTION_POINTER) + $past(INSTR_LENGTH) +
            16'(signed'($past(SIGNED_BRANCH_DISPLACEMENT)));
    endproperty
    property p_abs;
        s_br(BR_ABSOLUTE) |=> INSTRUCTION_POINTER == $past(IMMEDIATE_WORD);
    endproperty
    property p_call;
        s_br(BR_SHORT_CALL) |=>
            INSTRUCTION_POINTER == {5'h01, $past(SHORT_CALL_ADDR)};
    endproperty
    property p_table;
        s_br(BR_TABLE_CALL) |=> INSTRUCTION_POINTER == $past(TABLE_ENTRY);
    endproperty
    property p_saddr;
        s_op(OP_SHORT_DIRECT) |=> OPERAND_ADDR == {7'h7f,
            $past(IMMEDIATE_BYTE) < 8'h20, $past(IMMEDIATE_BYTE)};
    endproperty
    property p_sfr;
        s_op(OP_SPECIAL) |=> OPERAND_ADDR == {8'hff, $past(IMMEDIATE_BYTE)};
    endproperty
    property p_based;
        s_op(OP_BASED) |=> OPERAND_ADDR ==
            $past(BANK_REGS[63:48]) + {8'h00, $past(IMMEDIATE_BYTE)};
    endproperty
    property p_valid;
        OPERAND_REQ ##1 !OPERAND_REQ |-> OPERAND_VALID ##1 !OPERAND_VALID;
    endproperty
    a_seq: assert property (p_seq) else $error("step wrong");
    a_rel: assert property (p_rel) else $error("relative wrong");
    a_abs: assert property (p_abs) else $error("absolute wrong");
    a_call: assert property (p_call) else $error("call wrong");
    a_table: assert property (p_table) else $error("table wrong");
    a_saddr: assert property (p_saddr) else $error("short bad");
    a_sfr: assert property (p_sfr) else $error("special bad");
    a_based: assert property (p_based) else $error("based bad");
    a_valid: assert property (p_valid) else $error("valid bad");
endmodule
bind addr_gen addr_gen_properties u_addr_gen_properties (.*);

// ===== verification/table_memory.sv
`timescale 1ns/1ns
module table_memory (
    input wire logic [15:0] table_addr, // entry address
    output logic [15:0] table_entry // stored target
);
    // Each entry is tied to its own address, so a wrong index shows.
    always_comb begin
        table_entry = {~table_addr[7:0], table_addr[7:0]};
    end
endmodule

// ===== verification/cpu_address_generation_bench.sv
`timescale 1ns/1ns
module cpu_address_generation_bench;
    import addr_gen_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, fetch = 1'b0, req = 1'b0, psel = 1'b0;
    logic [2:0] len = 3'h0, code = 3'h0;
    logic [7:0] disp = 8'h00, imm = 8'h00;
    logic [15:0] ip, taddr, entry, oaddr;
    logic [1:0] pcode = 2'h0;
    logic [1:0] bank = 2'h2;
    logic is_reg, is_pair, valid;
    logic [4:0] idx;
    branch_mode_e bm = BR_NONE;
    operand_mode_e om = OP_IMPLIED;
    int miscompares = 0, comparisons = 0;
    always #5 clk = ~clk;
    addr_gen u_addr_gen (.REF_CLK(clk), .RST_B(rst_b), .FETCH_DONE(fetch),
        .INSTR_LENGTH(len), .BRANCH_MODE(bm),
        .SIGNED_BRANCH_DISPLACEMENT(disp), .IMMEDIATE_WORD(16'h1234),
        .SHORT_CALL_ADDR(11'h7ff), .OPCODE_BYTE(8'h3e), .TABLE_ENTRY(entry),
        .OPERAND_MODE(om), .IMMEDIATE_BYTE(imm), .BYTE_REG_CODE(code),
        .PAIR_REG_CODE(pcode), .PAIR_SELECT(psel), .BANK_SELECT_LOW(bank[0]),
        .BANK_SELECT_HIGH(bank[1]), .BANK_REGS(64'hffff_5678_9abc_def0),
        .OPERAND_REQ(req), .INSTRUCTION_POINTER(ip), .TABLE_ADDR(taddr),
        .OPERAND_ADDR(oaddr), .OPERAND_IS_REG(is_reg), .REG_INDEX(idx),
        .REG_IS_PAIR(is_pair), .OPERAND_VALID(valid));
    table_memory u_table_memory (.table_addr(taddr), .table_entry(entry));
    task check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task br(input branch_mode_e m, input logic [2:0] l, input logic [7:0] d,
            input logic [15:0] want);
        @(posedge clk);
        bm <= m;
        len <= l;
        disp <= d;
        fetch <= 1'b1;
        @(posedge clk);
        fetch <= 1'b0;
        #1 check(ip, want);
    endtask
    task op(input operand_mode_e m, input logic [7:0] i);
        @(posedge clk);
        om <= m;
        imm <= i;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        #1 check({15'h0000, valid}, 16'h0001);
    endtask
    task t_branch;
        br(BR_NONE, 3'h3, 8'h00, 16'h0003);
        br(BR_RELATIVE, 3'h2, 8'hff, 16'h0004);
        br(BR_RELATIVE, 3'h2, 8'h80, 16'hff86);
        br(BR_RELATIVE, 3'h2, 8'h7f, 16'h0007);
        br(BR_ABSOLUTE, 3'h3, 8'h00, 16'h1234);
        br(BR_SHORT_CALL, 3'h2, 8'h00, 16'h0fff);
        check(taddr, 16'h007e);
        br(BR_TABLE_CALL, 3'h1, 8'h00, 16'h817e);
        br(BR_REGISTER, 3'h1, 8'h00, 16'hdef0);
        $display("branch test done");
    endtask
    task t_operand;
        op(OP_SHORT_DIRECT, 8'h1f);
        check(oaddr, 16'hff1f);
        op(OP_SHORT_DIRECT, 8'h20);
        check(oaddr, 16'hfe20);
        op(OP_SPECIAL, 8'hcf);
        check(oaddr, 16'hffcf);
        op(OP_SPECIAL, 8'he0);
        check(oaddr, 16'hffe0);
        op(OP_DIRECT, 8'h00);
        check(oaddr, 16'h1234);
        op(OP_INDIRECT_POINTER, 8'h00);
        check(oaddr, 16'h5678);
        op(OP_INDIRECT_BASE, 8'h00);
        check(oaddr, 16'hffff);
        op(OP_BASED, 8'h02);
        check(oaddr, 16'h0001);
        op(OP_BASED_INDEX_HIGH, 8'h00);
        check(oaddr, 16'h0099);
        op(OP_BASED_INDEX_LOW, 8'h00);
        check(oaddr, 16'h00bb);
        $display("operand test done");
    endtask
    task t_regs;
        @(posedge clk);
        code <= REG_C;
        op(OP_REGISTER, 8'h00);
        check({10'h000, is_reg, idx}, 16'h0032);
        @(posedge clk);
        bank <= 2'h1;
        op(OP_REGISTER, 8'h00);
        check({10'h000, is_reg, idx}, 16'h002a);
        @(posedge clk);
        bank <= 2'h2;
        pcode <= PAIR_POINTER;
        psel <= 1'b1;
        op(OP_REGISTER, 8'h00);
        check({10'h000, is_pair, idx}, 16'h0034);
        op(OP_IMPLIED, 8'h00);
        check({10'h000, is_pair, idx}, 16'h0030);
        @(posedge clk);
        psel <= 1'b0;
        op(OP_IMPLIED, 8'h00);
        check({10'h000, is_pair, idx}, 16'h0011);
        $display("register test done");
    endtask
    task summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        #1 check(ip, RESET_POINTER);
        t_branch;
        t_operand;
        t_regs;
        summarize;
    end
    initial begin
        #100000;
        miscompares++;
        summarize;
    end
endmodule
